// ### include/pcps_pkg.sv
/*
 * Package for the paced counter and port streamer: the register map, the field
 * positions, reset values, the timing figures and the shared types.
 * Assumes one 40 MHz board clock and a plain strobe register port.
 */
// Summary of operation
// - Two free-running 24-bit pulse counters, fast inputs
// - Pacer timer periodically triggers counter capture
// - Second counter sampled two clocks (50 ns) after first
// - Readings into 1k FIFO, block moved at 512
// - Counters wrap to zero after full range
// - Capture never disturbs the running counter
// - Pacer zero captures A, or A and B
// - Pacer clocked internally or by external pin
// - Internal DMA or bus-master chosen by enable
// - Narrow format keeps low 16 count bits
// - Wide format keeps 24 bits, top byte zero
// - Wide sample format flag picks format
// - Static digital I/O stays usable meanwhile
// - Port stream: start port, count 1/2/4/8
// - Ports 16 lines wide, each in or out
// - Input and output rates set separately
// - Port streaming internal or external clock
// - Input and output streams run together
// - Regenerate mode cycles 64k-word onboard buffer
// - Buffered mode requests data, host refills
// - Pacer paces input, second timer paces output
// - Timer counts up, at compare reloads zero
// - Request more data at half empty
// - Output word: bits 18-16 port (used with wide flag), 15-0 data
package pcps_pkg;
    localparam int          CNT_W        = 24;
    localparam int          PORT_W       = 16;
    localparam int          NPORT        = 8;
    localparam int          IFIFO_DEPTH  = 1024;
    localparam int          IFIFO_AW     = 10;
    localparam logic [10:0] IFIFO_HALF   = 11'h200;
    localparam int          OBUF_AW      = 16;
    localparam logic [16:0] OBUF_HALF    = 17'h08000;
    localparam int          CLK_HZ       = 40_000_000;
    localparam int          SKEW_NS      = 30;
    // Worked in MHz so the product stays inside a 32-bit int
    localparam int          SKEW_CYC     = (SKEW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0]  A_CTRL       = 8'h00;
    localparam logic [7:0]  A_PACE_IN    = 8'h04;
    localparam logic [7:0]  A_PACE_OUT   = 8'h08;
    localparam logic [7:0]  A_PORTCFG    = 8'h0C;
    localparam logic [7:0]  A_STATUS     = 8'h10;
    localparam logic [7:0]  A_IFIFO      = 8'h14;
    localparam logic [7:0]  A_OBUF       = 8'h18;
    localparam logic [7:0]  A_CNT_A      = 8'h1C;
    localparam logic [7:0]  A_CNT_B      = 8'h20;
    localparam logic [7:0]  A_DOUT       = 8'h24;
    localparam logic [7:0]  A_DIN        = 8'h28;
    // Control bit positions
    localparam int          C_CNT_EN     = 0;
    localparam int          C_DUAL       = 1;
    localparam int          C_WIDE       = 2;
    localparam int          C_EXT_IN     = 3;
    localparam int          C_EXT_OUT    = 4;
    localparam int          C_BUSMASTER  = 5;
    localparam int          C_PIN_EN     = 6;
    localparam int          C_POUT_EN    = 7;
    localparam int          C_REGEN      = 8;
    localparam int          C_OVR_CLR    = 9;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] PACE_RST     = 32'h0000_0018;
    localparam logic [7:0]  PORTCFG_RST  = 8'h00;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } pcps_bus_t;

    typedef struct packed {
        logic        req;
        logic        busmaster;
    } pcps_xfer_t;
endpackage

// ### logic/pcps_top.sv
/*
 * Paced streaming engine: two event counters captured by a pacer into an input
 * FIFO drained at half full, port input streaming, and paced output streaming
 * from a regenerating or host-refilled 64k-word buffer.
 * Assumes pulse and pin inputs are asynchronous; the host drains the FIFO by
 * reading it after a block request and acknowledges with i_xfer_done.
 */
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module pcps_top (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire pcps_pkg::pcps_bus_t    i_bus,
    output logic [31:0]                 o_rdata,
    input  wire logic                   i_pulse_a,
    input  wire logic                   i_pulse_b,
    input  wire logic                   i_pacer_ext,
    input  wire logic                   i_outpace_ext,
    input  wire logic                   i_pacer_irq,
    input  wire logic [127:0]           i_port,
    output logic [127:0]                o_port,
    output logic [127:0]                o_port_oe,
    output logic                        o_pacer_out,
    output pcps_pkg::pcps_xfer_t        o_xfer,
    input  wire logic                   i_xfer_done,
    output logic                        o_data_req
);
    import pcps_pkg::*;

    logic [31:0]  ctrl_ff, pace_in_ff, pace_out_ff;
    logic [7:0]   portcfg_ff, dir_ff;
    logic [2:0]   sa_ff, sb_ff, sp_ff, sq_ff, irq_ff;
    logic [CNT_W-1:0] cnt_a_ff, cnt_b_ff;
    logic [31:0]  tin_ff, tout_ff;
    logic         tick_in, tick_out, pace_tog_ff;
    logic [31:0]  fifo_mem [IFIFO_DEPTH];
    logic [IFIFO_AW:0] wp_ff, rp_ff;
    logic [10:0]  level;
    logic         ovr_ff, push, pop;
    logic [31:0]  push_data;
    logic [18:0]  oword [2**OBUF_AW];
    logic [OBUF_AW-1:0] orp_ff, owp_ff;
    logic [16:0]  olevel_ff, owr_cnt_ff;
    logic [127:0] pin_s1_ff, pin_s2_ff, dout_ff;
    logic [2:0]   in_idx_ff, out_idx_ff;
    logic [3:0]   skew_ff;
    logic [31:0]  rdata_ff;
    logic         xfer_ff, req_ff;

    typedef enum logic [1:0] {PCPS_IDLE, PCPS_CAP_B} pcps_cap_t;
    pcps_cap_t cap_ff;

    function automatic logic [31:0] fmt(input logic [CNT_W-1:0] v, input logic wide);
        fmt = wide ? {8'h00, v} : {16'h0000, v[15:0]};
    endfunction

    function automatic logic [3:0] nports(input logic [1:0] code);
        nports = 4'h1 << code;
    endfunction

    // Two-stage synchronisers; edge detect on the second and a third stage
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            sa_ff <= 3'h0; sb_ff <= 3'h0; sp_ff <= 3'h0; sq_ff <= 3'h0; irq_ff <= 3'h0;
            pin_s1_ff <= '0; pin_s2_ff <= '0;
        end
        else
        begin
            sa_ff  <= {sa_ff[1:0], i_pulse_a};
            sb_ff  <= {sb_ff[1:0], i_pulse_b};
            sp_ff  <= {sp_ff[1:0], i_pacer_ext};
            sq_ff  <= {sq_ff[1:0], i_outpace_ext};
            irq_ff <= {irq_ff[1:0], i_pacer_irq};
            pin_s1_ff <= i_port;
            pin_s2_ff <= pin_s1_ff;
        end

    // Pulse counters: rise wraps naturally at full range, capture never touches them
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            cnt_a_ff <= '0;
            cnt_b_ff <= '0;
        end
        else
        begin
            if (sa_ff[1] && !sa_ff[2])
                cnt_a_ff <= cnt_a_ff + 24'h000001;
            if (sb_ff[1] && !sb_ff[2])
                cnt_b_ff <= cnt_b_ff + 24'h000001;
        end

    // Pacing timers: count from zero, at compare reload zero and fire one tick
    wire in_clk_en  = ctrl_ff[C_EXT_IN]  ? (sp_ff[1] && !sp_ff[2]) : 1'b1;
    wire out_clk_en = ctrl_ff[C_EXT_OUT] ? (sq_ff[1] && !sq_ff[2]) : 1'b1;
    wire in_run     = ctrl_ff[C_CNT_EN] | ctrl_ff[C_PIN_EN];
    assign tick_in  = in_run && in_clk_en && (tin_ff == pace_in_ff);
    assign tick_out = ctrl_ff[C_POUT_EN] && out_clk_en && (tout_ff == pace_out_ff);

    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            tin_ff <= '0; tout_ff <= '0; pace_tog_ff <= 1'b0;
        end
        else
        begin
            if (!in_run)
                tin_ff <= '0;
            else if (in_clk_en)
                tin_ff <= tick_in ? 32'h0 : tin_ff + 32'h1;
            if (!ctrl_ff[C_POUT_EN])
                tout_ff <= '0;
            else if (out_clk_en)
                tout_ff <= tick_out ? 32'h0 : tout_ff + 32'h1;
            if (tick_in)
                pace_tog_ff <= ~pace_tog_ff;
        end

    // Dual mode triggers from the jumpered pacer interrupt input
    wire cap_trig = ctrl_ff[C_CNT_EN] &&
                    (ctrl_ff[C_DUAL] ? (irq_ff[1] && !irq_ff[2]) : tick_in);

    // Capture sequencer: A now, B after the skew delay
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            cap_ff <= PCPS_IDLE; skew_ff <= 4'h0;
        end
        else
            case (cap_ff)
                PCPS_IDLE:
                    if (cap_trig && ctrl_ff[C_DUAL])
                    begin
                        cap_ff  <= PCPS_CAP_B;
                        skew_ff <= 4'(SKEW_CYC - 1);
                    end
                PCPS_CAP_B:
                    if (skew_ff == 4'h0)
                        cap_ff <= PCPS_IDLE;
                    else
                        skew_ff <= skew_ff - 4'h1;
                default:
                    cap_ff <= PCPS_IDLE;
            endcase

    wire cap_b = (cap_ff == PCPS_CAP_B) && (skew_ff == 4'h0);
    wire port_in_tick = ctrl_ff[C_PIN_EN] && !ctrl_ff[C_CNT_EN] && tick_in;
    wire [2:0] in_port = 3'(portcfg_ff[2:0] + in_idx_ff);
    always_comb
    begin
        push      = 1'b0;
        push_data = '0;
        if (cap_b)
        begin
            push = 1'b1; push_data = fmt(cnt_b_ff, ctrl_ff[C_WIDE]);
        end
        else if (cap_trig)
        begin
            push = 1'b1; push_data = fmt(cnt_a_ff, ctrl_ff[C_WIDE]);
        end
        else if (port_in_tick)
        begin
            push = 1'b1; push_data = {16'h0000, pin_s2_ff[in_port*PORT_W +: PORT_W]};
        end
    end

    // Input FIFO; a trigger colliding with the B slot always loses its A reading
    assign level = 11'(wp_ff - rp_ff);
    assign pop   = i_bus.rd && (i_bus.addr == A_IFIFO) && (level != 11'h0);
    wire clr_ovr = i_bus.wr && (i_bus.addr == A_CTRL) && i_bus.wdata[C_OVR_CLR];
    always_ff @(posedge i_clk)
        if (push && !ovr_ff && level != 11'(IFIFO_DEPTH))
            fifo_mem[wp_ff[IFIFO_AW-1:0]] <= push_data;
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            wp_ff <= '0; rp_ff <= '0; ovr_ff <= 1'b0; in_idx_ff <= 3'h0;
        end
        else
        begin
            if (push && !ovr_ff && level != 11'(IFIFO_DEPTH))
                wp_ff <= wp_ff + 11'h1;
            if (pop)
                rp_ff <= rp_ff + 11'h1;
            if (push && level == 11'(IFIFO_DEPTH))
                ovr_ff <= 1'b1;
            else if (clr_ovr)
                ovr_ff <= 1'b0;
            if (!ctrl_ff[C_PIN_EN])
                in_idx_ff <= 3'h0;
            else if (port_in_tick)
                in_idx_ff <= 3'((in_idx_ff + 3'h1) & 3'(nports(portcfg_ff[4:3]) - 4'h1));
        end

    // Block transfer: one request per 512 words, style set by bus-master enable
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
            xfer_ff <= 1'b0;
        else if (i_xfer_done)
            xfer_ff <= 1'b0;
        else if (level >= IFIFO_HALF)
            xfer_ff <= 1'b1;

    // Output buffer and stream
    wire obuf_wr = i_bus.wr && (i_bus.addr == A_OBUF);
    wire [2:0] out_port = ctrl_ff[C_WIDE] ? oword[orp_ff][18:16]
                          : 3'(portcfg_ff[2:0] + out_idx_ff);
    wire out_go = tick_out && (ctrl_ff[C_REGEN] || olevel_ff != 17'h0);
    always_ff @(posedge i_clk)
        if (obuf_wr)
            oword[owp_ff] <= i_bus.wdata[18:0];
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            orp_ff <= '0; owp_ff <= '0; olevel_ff <= '0; owr_cnt_ff <= '0;
            out_idx_ff <= 3'h0; req_ff <= 1'b0;
        end
        else
        begin
            if (obuf_wr)
                owp_ff <= owp_ff + 16'h1;
            if (out_go)
            begin
                orp_ff <= (ctrl_ff[C_REGEN] && orp_ff == 16'(owr_cnt_ff - 17'h1))
                          ? 16'h0 : orp_ff + 16'h1;
                out_idx_ff <= 3'((out_idx_ff + 3'h1) & 3'(nports(portcfg_ff[4:3]) - 4'h1));
            end
            else if (!ctrl_ff[C_POUT_EN])
                out_idx_ff <= 3'h0;
            if (obuf_wr && !(out_go && !ctrl_ff[C_REGEN]))
                olevel_ff <= olevel_ff + 17'h1;
            else if (!obuf_wr && out_go && !ctrl_ff[C_REGEN])
                olevel_ff <= olevel_ff - 17'h1;
            if (obuf_wr && owr_cnt_ff != 17'h10000)
                owr_cnt_ff <= owr_cnt_ff + 17'h1;
            req_ff <= ctrl_ff[C_POUT_EN] && !ctrl_ff[C_REGEN]
                      && (olevel_ff <= OBUF_HALF);
        end

    // Port drive: streamed output ports and static output share one register
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
            dout_ff <= '0;
        else if (out_go && dir_ff[out_port])
            dout_ff[out_port*PORT_W +: PORT_W] <= oword[orp_ff][15:0];
        else if (i_bus.wr && i_bus.addr == A_DOUT)
            dout_ff[i_bus.wdata[18:16]*PORT_W +: PORT_W] <= i_bus.wdata[15:0];

    // Registers
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            ctrl_ff <= CTRL_RST; pace_in_ff <= PACE_RST; pace_out_ff <= PACE_RST;
            portcfg_ff <= PORTCFG_RST; dir_ff <= 8'h00;
        end
        else if (i_bus.wr)
            case (i_bus.addr)
                A_CTRL:     ctrl_ff <= {22'h0, 1'b0, i_bus.wdata[8:0]};
                A_PACE_IN:  pace_in_ff <= i_bus.wdata;
                A_PACE_OUT: pace_out_ff <= i_bus.wdata;
                A_PORTCFG:
                begin
                    portcfg_ff <= {3'h0, i_bus.wdata[4:0]};
                    dir_ff     <= i_bus.wdata[15:8];
                end
                default: ;
            endcase

    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
            rdata_ff <= '0;
        else if (i_bus.rd)
            case (i_bus.addr)
                A_CTRL:     rdata_ff <= ctrl_ff;
                A_PACE_IN:  rdata_ff <= pace_in_ff;
                A_PACE_OUT: rdata_ff <= pace_out_ff;
                A_PORTCFG:  rdata_ff <= {16'h0, dir_ff, portcfg_ff};
                A_STATUS:   rdata_ff <= {12'h0, olevel_ff == 17'h0, ovr_ff, req_ff,
                                         xfer_ff, level, 5'h0};
                A_IFIFO:    rdata_ff <= (level != 11'h0) ? fifo_mem[rp_ff[IFIFO_AW-1:0]] : '0;
                A_CNT_A:    rdata_ff <= {8'h00, cnt_a_ff};
                A_CNT_B:    rdata_ff <= {8'h00, cnt_b_ff};
                A_DIN:      rdata_ff <= {16'h0, pin_s2_ff[i_bus.wdata[2:0]*PORT_W +: PORT_W]};
                default:    rdata_ff <= '0;
            endcase
        else
            rdata_ff <= '0;

    // Read data straight from its register, one cycle after the strobe
    assign o_rdata = rdata_ff;

    // Outputs from flip-flops
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            o_port <= '0; o_port_oe <= '0; o_pacer_out <= 1'b0;
            o_xfer <= '0; o_data_req <= 1'b0;
        end
        else
        begin
            o_port      <= dout_ff;
            for (int i = 0; i < NPORT; i++)
                o_port_oe[i*PORT_W +: PORT_W] <= {PORT_W{dir_ff[i]}};
            o_pacer_out <= pace_tog_ff;
            o_xfer      <= '{req: xfer_ff, busmaster: ctrl_ff[C_BUSMASTER]};
            o_data_req  <= req_ff;
        end

    // Assertions
    property p_wrap;
        @(posedge i_clk) disable iff (i_rst)
        (cnt_a_ff == 24'hFFFFFF && sa_ff[1] && !sa_ff[2]) |=> cnt_a_ff == 24'h000000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter A did not wrap");

    property p_nodisturb;
        @(posedge i_clk) disable iff (i_rst)
        (cap_trig && !(sa_ff[1] && !sa_ff[2])) |=> cnt_a_ff == $past(cnt_a_ff);
    endproperty
    a_nodisturb: assert property (p_nodisturb) else $error("capture disturbed counter");

    property p_skew;
        @(posedge i_clk) disable iff (i_rst)
        (cap_ff == PCPS_IDLE && cap_trig && ctrl_ff[C_DUAL]) |-> ##2 cap_b;
    endproperty
    a_skew: assert property (p_skew) else $error("B not captured after skew");

    property p_reload;
        @(posedge i_clk) disable iff (i_rst)
        tick_in |=> tin_ff == 32'h0;
    endproperty
    a_reload: assert property (p_reload) else $error("pacer did not reload zero");

    property p_narrow;
        @(posedge i_clk) disable iff (i_rst)
        (push && !ctrl_ff[C_WIDE]) |-> push_data[31:16] == 16'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow sample too wide");

    property p_ovr;
        @(posedge i_clk) disable iff (i_rst)
        ovr_ff && !clr_ovr |=> ovr_ff && $stable(wp_ff);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not sticky");

    property p_half;
        @(posedge i_clk) disable iff (i_rst)
        (level >= IFIFO_HALF && !i_xfer_done) |-> ##[1:2] o_xfer.req;
    endproperty
    a_half: assert property (p_half) else $error("no block request at half");

    property p_req;
        @(posedge i_clk) disable iff (i_rst)
        (ctrl_ff[C_POUT_EN] && !ctrl_ff[C_REGEN] && olevel_ff <= OBUF_HALF)
            |-> ##2 o_data_req;
    endproperty
    a_req: assert property (p_req) else $error("no data request at half empty");
endmodule

// ### testbench/pcps_far_model.sv
/*
 * Far-side model: two pulse sources, the port input lines and the pacer jumper.
 * Assumes the bench starts each burst with a one-cycle go pulse.
 */
`timescale 1ns/1ps
module pcps_far_model (
    input  wire logic         i_clk,
    input  wire logic         i_go,
    input  wire logic [7:0]   i_na,
    input  wire logic [7:0]   i_nb,
    input  wire logic         i_pacer_out,
    output logic              o_pulse_a,
    output logic              o_pulse_b,
    output logic              o_irq,
    output logic [127:0]      o_port
);
    logic [1:0] div_ff = 2'h0;
    logic [8:0] ka_ff  = 9'h0;
    logic [8:0] kb_ff  = 9'h0;
    // Four clocks a phase, so the input sync never drops an edge
    always_ff @(posedge i_clk)
    begin
        div_ff <= div_ff + 2'h1;
        if (i_go)
        begin
            ka_ff <= {i_na, 1'b0};
            kb_ff <= {i_nb, 1'b0};
        end
        else if (div_ff == 2'h3)
        begin
            ka_ff <= ka_ff - 9'(ka_ff != 9'h0);
            kb_ff <= kb_ff - 9'(kb_ff != 9'h0);
        end
    end
    assign o_pulse_a = ka_ff[0];
    assign o_pulse_b = kb_ff[0];
    assign o_irq     = i_pacer_out;
    for (genvar p = 0; p < 8; p++)
    begin : g_port
        assign o_port[16*p +: 16] = 16'hC3A0 + 16'(p);
    end
endmodule

// ### testbench/pcps_top_tb.sv
/*
 * Self-checking bench: register table, counting, capture formats, FIFO
 * hand-off, overrun, port streaming and output streaming.
 * Assumes pcps_far_model supplies pulses, port lines and the pacer jumper.
 */
`timescale 1ns/1ps
module pcps_top_tb;
    import pcps_pkg::*;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] v;
        logic [31:0] e;
    } pcps_row_t;
    localparam pcps_row_t ROWS [8] = '{
        '{1'b0, A_CTRL, 32'h0, CTRL_RST}, '{1'b0, A_PACE_IN, 32'h0, PACE_RST},
        '{1'b0, A_PACE_OUT, 32'h0, PACE_RST}, '{1'b0, A_PORTCFG, 32'h0, 32'h0},
        '{1'b0, A_STATUS, 32'h0, 32'h0008_0000}, '{1'b1, 8'h3C, 32'hFFFF_FFFF, 32'h0},
        '{1'b1, A_PACE_OUT, 32'h7, 32'h7}, '{1'b1, A_PACE_IN, 32'h5, 32'h5}};
    localparam logic [7:0] PCFG [4] = '{8'h03, 8'h09, 8'h12, 8'h18};
    logic           i_clk;
    logic           i_rst;
    pcps_bus_t      bus;
    logic [31:0]    o_rdata;
    logic           pa;
    logic           pb;
    logic           pext;
    logic           irq;
    logic [127:0]   pin;
    logic [127:0]   pout;
    logic [127:0]   poe;
    logic           pacer;
    pcps_xfer_t     xfer;
    logic           done;
    logic           dreq;
    logic [7:0]     na;
    logic [7:0]     nb;
    logic           go;
    int             n_mismatch;
    int             total_checks;
    int             cyc;
    int             t;
    logic [31:0]    d;
    logic [31:0]    q[$];

    pcps_top dut_u (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_bus         (bus),
        .o_rdata       (o_rdata),
        .i_pulse_a     (pa),
        .i_pulse_b     (pb),
        .i_pacer_ext   (pext),
        .i_outpace_ext (1'b0),
        .i_pacer_irq   (irq),
        .i_port        (pin),
        .o_port        (pout),
        .o_port_oe     (poe),
        .o_pacer_out   (pacer),
        .o_xfer        (xfer),
        .i_xfer_done   (done),
        .o_data_req    (dreq)
    );
    pcps_far_model far_u (
        .i_clk       (i_clk),
        .i_go        (go),
        .i_na        (na),
        .i_nb        (nb),
        .i_pacer_out (pacer),
        .o_pulse_a   (pa),
        .o_pulse_b   (pb),
        .o_irq       (irq),
        .o_port      (pin)
    );

    initial
    begin
        i_clk = 1'b0;
        forever
            #12.5 i_clk = ~i_clk;
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Generous ceiling; the full run needs about 6k cycles
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string s);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        bus <= '{1'b1, 1'b0, a, v};
        @(posedge i_clk);
        bus <= '0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge i_clk);
        bus <= '0;
        #1 d = o_rdata;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic drain();
        rd(A_STATUS);
        q.delete();
        repeat (int'(d[15:5]))
        begin
            rd(A_IFIFO);
            q.push_back(d);
        end
    endtask
    task automatic stream(input logic [31:0] c, input int n);
        wr(A_CTRL, c);
        waitc(n);
        wr(A_CTRL, 32'h0);
        drain();
    endtask
    task automatic wait_tog();
        logic p0;
        p0 = pacer;
        t = 0;
        while (pacer === p0 && t < 100)
        begin
            @(posedge i_clk);
            #1 t++;
        end
    endtask

    initial
    begin
        i_rst = 1'b1;
        bus = '0;
        pext = 1'b0;
        done = 1'b0;
        na = 8'h25;
        nb = 8'h14;
        go = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        cyc = 0;
        waitc(4);
        chk(32'h0, 32'({pacer, dreq, xfer}), "outputs in reset");
        i_rst <= 1'b0;
        foreach (ROWS[k])
        begin
            if (ROWS[k].w)
                wr(ROWS[k].a, ROWS[k].v);
            rd(ROWS[k].a);
            chk(ROWS[k].e, d, "register");
        end
        go <= 1'b1;
        waitc(1);
        go <= 1'b0;
        waitc(400);
        rd(A_CNT_A);
        chk(32'h25, d, "count a");
        rd(A_CNT_B);
        chk(32'h14, d, "count b");
        wr(A_PORTCFG, 32'h0800);
        wr(A_CTRL, 32'h1);
        wr(A_DOUT, 32'h0003_1234);
        wait_tog();
        wait_tog();
        chk(32'h6, 32'(t), "pacer period");
        waitc(30);
        chk(32'h1234, 32'(pout[63:48]), "static out");
        stream(32'h1, 10);
        foreach (q[k])
            chk(32'h25, 32'(q[k][15:0]), "narrow reading");
        nb <= 8'h0;
        go <= 1'b1;
        waitc(1);
        go <= 1'b0;
        stream(32'h5, 320);
        for (int k = 1; k < q.size(); k++)
            chk(32'h0, 32'(q[k][23:0] < q[k-1][23:0]), "rising reading");
        chk(32'h4A, 32'(q[q.size()-1][23:0]), "wide reading");
        rd(A_CNT_A);
        chk(32'h4A, d, "count after capture");
        stream(32'h3, 40);
        chk(32'h4A, 32'(q[0][15:0]), "dual first");
        chk(32'h14, 32'(q[1][15:0]), "dual second");
        foreach (PCFG[j])
        begin
            wr(A_PORTCFG, {24'h0, PCFG[j]});
            stream(32'h40, 100);
            foreach (q[k])
                chk(32'(16'hC3A0 + PCFG[j][2:0] + k % (1 << PCFG[j][4:3])),
                    32'(q[k][15:0]), "port word");
        end
        wr(A_PACE_IN, 32'h1);
        wr(A_CTRL, 32'h21);
        t = 0;
        while (xfer.req !== 1'b1 && t < 3000)
        begin
            @(posedge i_clk);
            #1 t++;
        end
        rd(A_STATUS);
        chk(32'h1, 32'(d[15:5] inside {[11'h200:11'h204]}), "half full");
        chk(32'h1, 32'(xfer.busmaster), "bus master");
        waitc(1200);
        rd(A_STATUS);
        chk(32'h0005_8000, d & 32'h0005_FFE0, "full status");
        wr(A_CTRL, 32'h0);
        drain();
        chk(32'd1024, 32'(q.size()), "full count");
        @(posedge i_clk);
        done <= 1'b1;
        @(posedge i_clk);
        done <= 1'b0;
        waitc(2);
        chk(32'h0, 32'(xfer.req), "request cleared");
        wr(A_CTRL, 32'h200);
        rd(A_STATUS);
        chk(32'h0, 32'(d[18]), "overrun cleared");
        wr(A_CTRL, 32'h9);
        repeat (8)
        begin
            waitc(4);
            pext <= 1'b1;
            waitc(4);
            pext <= 1'b0;
        end
        stream(32'h9, 8);
        chk(32'h4, 32'(q.size()), "external pacing");
        wr(A_PORTCFG, 32'h0800);
        wr(A_OBUF, 32'h0003_5A3C);
        wr(A_CTRL, 32'hC4);
        waitc(40);
        chk(32'h1, 32'(dreq), "data request");
        chk(32'h5A3C, 32'(pout[63:48]), "output word");
        chk(32'hFFFF, 32'(poe[63:48]), "output enable");
        wr(A_CTRL, 32'h0);
        drain();
        chk(32'hC3A0, 32'(q[0][15:0]), "input beside output");
        wrap_up();
    end
endmodule
